// [clk_src_map.vh]
// Contract
// - select code 11 runs system clock straight from the external clock pin.
// - in direct drive the system clock keeps the input clock's duty cycle.
// - select 10 with bypass 1 runs system clock from oscillator through divider.
// - divide factor is divider field plus one; output is oscillator over factor.
// - factor one in prescaler mode passes the oscillator level and duty cycle.
// - divider reaches factor 1024, giving oscillator frequency over 1024.
// - select 10 with bypass 0 enables the loop and uses its output.
// - select 00 runs system clock from the low-frequency wakeup source.
`ifndef CLK_SRC_MAP_VH
`define CLK_SRC_MAP_VH

// =====================================
// select field codes
`define SEL_WAKEUP 2'h0
`define SEL_ALT 2'h1
`define SEL_LOOP 2'h2
`define SEL_DIRECT 2'h3

// =====================================
// divider field
`define DIV_FIELD_W 10
`define DIV_FACTOR_W 11
`define DIV_FACTOR_MAX 11'h400

// =====================================
// internal source codes and reset values
`define MODE_WAKEUP 2'h0
`define MODE_LOOP 2'h1
`define MODE_PRESC 2'h2
`define MODE_DIRECT 2'h3
`define RST_MODE 2'h0
`define SYNC_STAGES 3

`endif

// [level_sync.v]
`timescale 1ns/10ps
`default_nettype none
`include "clk_src_map.vh"

// =====================================
// three-stage level synchroniser, output moves when stages two and three agree
module level_sync #(
  parameter WIDTH = 5
) (
  input wire clock,
  input wire rst,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] s1_ff;
  reg [WIDTH-1:0] s2_ff;
  reg [WIDTH-1:0] s3_ff;
  genvar i;

  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clock) begin
        if (rst) begin
          s1_ff[i] <= 1'b0;
          s2_ff[i] <= 1'b0;
          s3_ff[i] <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          s1_ff[i] <= din[i];
          s2_ff[i] <= s1_ff[i];
          s3_ff[i] <= s2_ff[i];
          if (s2_ff[i] == s3_ff[i]) begin
            dout[i] <= s3_ff[i];
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// [sys_clk_gen.v]
`timescale 1ns/10ps
`default_nettype none
`include "clk_src_map.vh"

// =====================================
// system clock source selection and prescaler
module sys_clk_gen (
  input wire clock,
  input wire rst,
  input wire [1:0] sys_clk_source_sel,
  input wire osc_bypass_sel,
  input wire [`DIV_FIELD_W-1:0] out_div_field,
  input wire osc_int_sel,
  input wire ext_clk_pin,
  input wire crystal_in_pin,
  input wire int_clk_src,
  input wire loop_clk,
  input wire wakeup_clk,
  output reg sys_clk,
  output reg loop_enable,
  output reg [1:0] active_mode,
  output wire switch_pending
);

  // =====================================
  // source sampling
  wire [4:0] raw_src;
  wire [4:0] src_lvl;
  wire ext_lvl;
  wire xtal_lvl;
  wire int_lvl;
  wire loop_lvl;
  wire wu_lvl;

  assign raw_src = {wakeup_clk, loop_clk, int_clk_src, crystal_in_pin, ext_clk_pin};

  level_sync #(
    .WIDTH(5)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .din(raw_src),
    .dout(src_lvl)
  );

  assign ext_lvl = src_lvl[0];
  assign xtal_lvl = src_lvl[1];
  assign int_lvl = src_lvl[2];
  assign loop_lvl = src_lvl[3];
  assign wu_lvl = src_lvl[4];

  // =====================================
  // requested mode decode
  function [1:0] decode_mode;
    input [1:0] sel;
    input bypass;
    begin
      case (sel)
        `SEL_DIRECT: begin
          decode_mode = `MODE_DIRECT;
        end
        `SEL_LOOP: begin
          if (bypass) begin
            decode_mode = `MODE_PRESC;
          end else begin
            decode_mode = `MODE_LOOP;
          end
        end
        `SEL_WAKEUP: begin
          decode_mode = `MODE_WAKEUP;
        end
        default: begin
          decode_mode = `MODE_WAKEUP;
        end
      endcase
    end
  endfunction

  wire [1:0] req_mode;
  assign req_mode = decode_mode(sys_clk_source_sel, osc_bypass_sel);

  // =====================================
  // prescaler
  reg osc_prev_ff;
  reg osc_sel_ff;
  reg [`DIV_FACTOR_W-1:0] factor_ff;
  reg [`DIV_FACTOR_W-1:0] cnt_ff;
  reg div_lvl_ff;
  reg [`DIV_FACTOR_W-1:0] nxt_cnt;
  reg [`DIV_FACTOR_W-1:0] nxt_factor;
  reg nxt_div_lvl;
  wire osc_sel_safe;
  wire osc_lvl;
  wire osc_rise;
  wire [`DIV_FACTOR_W-1:0] req_factor;
  wire wrap;
  wire [`DIV_FACTOR_W-1:0] half;
  wire presc_lvl;

  // =====================================
  // oscillator choice, moved only while both candidates are low
  assign osc_sel_safe = !xtal_lvl && !int_lvl;

  always @(posedge clock) begin
    if (rst) begin
      osc_sel_ff <= 1'b0;
    end else if (osc_sel_safe) begin
      osc_sel_ff <= osc_int_sel;
    end
  end

  assign osc_lvl = osc_sel_ff ? int_lvl : xtal_lvl;
  assign osc_rise = osc_lvl & ~osc_prev_ff;
  // field plus one, up to 1024
  assign req_factor = {1'b0, out_div_field} + `DIV_FACTOR_W'h001;
  assign wrap = (cnt_ff == factor_ff - `DIV_FACTOR_W'h001);
  assign half = factor_ff >> 1;

  // =====================================
  // divider next state
  always @* begin
    nxt_cnt = cnt_ff;
    nxt_factor = factor_ff;
    nxt_div_lvl = div_lvl_ff;
    if (osc_rise) begin
      if (wrap) begin
        // new factor only taken at the period boundary
        nxt_cnt = {`DIV_FACTOR_W{1'b0}};
        nxt_factor = req_factor;
        nxt_div_lvl = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + `DIV_FACTOR_W'h001;
        if (nxt_cnt == half) begin
          nxt_div_lvl = 1'b0;
        end
      end
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      osc_prev_ff <= 1'b0;
      factor_ff <= `DIV_FACTOR_W'h001;
      cnt_ff <= {`DIV_FACTOR_W{1'b0}};
      div_lvl_ff <= 1'b0;
    end else begin
      osc_prev_ff <= osc_lvl;
      factor_ff <= nxt_factor;
      cnt_ff <= nxt_cnt;
      div_lvl_ff <= nxt_div_lvl;
    end
  end

  // factor one follows the oscillator level directly
  assign presc_lvl = (factor_ff == `DIV_FACTOR_W'h001) ? osc_lvl : div_lvl_ff;

  // =====================================
  // level of each mode's source
  function source_level;
    input [1:0] mode;
    input l_wu;
    input l_loop;
    input l_presc;
    input l_ext;
    begin
      case (mode)
        `MODE_DIRECT: begin
          source_level = l_ext;
        end
        `MODE_PRESC: begin
          source_level = l_presc;
        end
        `MODE_LOOP: begin
          source_level = l_loop;
        end
        default: begin
          source_level = l_wu;
        end
      endcase
    end
  endfunction

  wire cur_lvl;
  wire req_lvl;
  assign cur_lvl = source_level(active_mode, wu_lvl, loop_lvl, presc_lvl, ext_lvl);
  assign req_lvl = source_level(req_mode, wu_lvl, loop_lvl, presc_lvl, ext_lvl);
  assign switch_pending = (req_mode != active_mode);

  // =====================================
  // glitch-free switch: change only while both old and new levels are low
  reg [1:0] nxt_active_mode;
  reg nxt_sys_clk;
  wire switch_safe;

  assign switch_safe = switch_pending && !sys_clk && !cur_lvl && !req_lvl;

  always @* begin
    nxt_active_mode = active_mode;
    nxt_sys_clk = cur_lvl;
    if (switch_safe) begin
      // output held low across the edge that swaps the source
      nxt_active_mode = req_mode;
      nxt_sys_clk = 1'b0;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      active_mode <= `RST_MODE;
      sys_clk <= 1'b0;
      loop_enable <= 1'b0;
    end else begin
      active_mode <= nxt_active_mode;
      sys_clk <= nxt_sys_clk;
      // loop kept running until the switch away from it completes
      loop_enable <= (req_mode == `MODE_LOOP) || (active_mode == `MODE_LOOP);
    end
  end

endmodule
`default_nettype wire

// [sys_clk_gen_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module sys_clk_gen_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] sys_clk_source_sel,
  input wire logic osc_bypass_sel,
  input wire logic [9:0] out_div_field,
  input wire logic osc_int_sel,
  input wire logic ext_clk_pin,
  input wire logic crystal_in_pin,
  input wire logic int_clk_src,
  input wire logic wakeup_clk,
  input wire logic sys_clk,
  input wire logic loop_enable,
  input wire logic [1:0] active_mode,
  input wire logic switch_pending
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [4:0] stab_ff;
  logic [12:0] cfg_ff;
  logic [12:0] pend_ff;
  wire logic osc = osc_int_sel ? int_clk_src : crystal_in_pin;
  wire logic [12:0] cfg = {active_mode, out_div_field, osc_int_sel};
  // cycles since mode or divider setup last moved, and cycles a switch has waited
  always @(posedge clock) begin
    cfg_ff <= cfg;
    stab_ff <= (rst || cfg_ff != cfg) ? 5'h0 : stab_ff + {4'h0, stab_ff != 5'h1f};
    pend_ff <= (rst || !switch_pending) ? 13'h0 : pend_ff + {12'h0, pend_ff != 13'h1fff};
  end
  AST_RST: assert property ($fell(rst) |-> active_mode == 2'h0 && !sys_clk && !loop_enable) else $error("bad reset");
  AST_SW_LOW: assert property ($changed(active_mode) |-> !sys_clk && !$past(sys_clk))
    else $error("switch high");
  AST_PEND: assert property (pend_ff < 13'h1770) else $error("switch stuck");
  AST_DIRECT: assert property (active_mode == 2'h3 && stab_ff > 5'h8 |->
    sys_clk == $past(ext_clk_pin, 4) || sys_clk == $past(ext_clk_pin, 5)) else $error("direct");
  AST_WAKE: assert property (active_mode == 2'h0 && stab_ff > 5'h8 |->
    sys_clk == $past(wakeup_clk, 4) || sys_clk == $past(wakeup_clk, 5)) else $error("wakeup");
  AST_PRE1: assert property (active_mode == 2'h2 && out_div_field == 10'h0 && stab_ff > 5'h1c |->
    sys_clk == $past(osc, 4) || sys_clk == $past(osc, 5)) else $error("factor one");
  AST_LOOP: assert property (sys_clk_source_sel == 2'h2 && !osc_bypass_sel |=> loop_enable)
    else $error("loop");
  AST_PRE: assert property (sys_clk_source_sel == 2'h2 && osc_bypass_sel && !switch_pending |->
    active_mode == 2'h2) else $error("prescaler");
  cover property (active_mode == 2'h3);
  cover property (active_mode == 2'h1 && loop_enable);
  cover property (active_mode == 2'h2 && out_div_field == 10'h3ff);
endmodule
bind sys_clk_gen sys_clk_gen_chk i_chk (.*);
`default_nettype wire

// [clk_src_model.sv]
`timescale 1ns/10ps
`default_nettype none
module clk_src_model (
  input wire logic clock,
  output logic ext_clk_pin,
  output logic crystal_in_pin,
  output logic int_clk_src,
  output logic loop_clk,
  output logic wakeup_clk
);
  int unsigned cnt_ff = 0;
  always @(posedge clock) cnt_ff <= cnt_ff + 1;
  // free-running sources, half periods in system cycles
  // direct source is uneven, three high and four low, so duty is checkable
  assign ext_clk_pin = cnt_ff % 7 < 3;
  assign crystal_in_pin = cnt_ff / 3 % 2 == 1;
  assign int_clk_src = cnt_ff / 4 % 2 == 1;
  assign loop_clk = cnt_ff / 3 % 2 == 1;
  assign wakeup_clk = cnt_ff / 5 % 2 == 1;
endmodule
`default_nettype wire

// [system_clock_source_prescaler_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module system_clock_source_prescaler_tb;
  logic clock = 0, rst = 1, osc_bypass_sel = 0, osc_int_sel = 0;
  logic [1:0] sys_clk_source_sel = 2'h0;
  logic [9:0] out_div_field = 10'h0;
  logic ext_clk_pin, crystal_in_pin, int_clk_src, loop_clk, wakeup_clk, sys_clk, loop_enable, switch_pending;
  logic [1:0] active_mode;
  int miscompares = 0, checks_done = 0, cycles = 0, hi, per;
  always #50 clock = ~clock;
  clk_src_model i_src (.*);
  sys_clk_gen i_dut (.*);
  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  // one full sys_clk period from a rising edge
  task automatic meas();
    hi = 0;
    @(negedge clock);
    while (sys_clk !== 1'b0) @(negedge clock);
    while (sys_clk !== 1'b1) @(negedge clock);
    while (sys_clk === 1'b1) begin
      hi++;
      @(negedge clock);
    end
    per = hi;
    while (sys_clk === 1'b0) begin
      per++;
      @(negedge clock);
    end
  endtask
  task automatic cfg(logic [1:0] sel, logic byp, logic [9:0] fld, logic oi, logic [1:0] mode);
    @(posedge clock);
    sys_clk_source_sel <= sel;
    osc_bypass_sel <= byp;
    out_div_field <= fld;
    osc_int_sel <= oi;
    @(posedge clock);
    // a switch into a long divided high phase waits for it to end
    for (int i = 0; i < 5000 && active_mode !== mode; i++) @(posedge clock);
    chk("active_mode", {30'h0, active_mode}, {30'h0, mode});
    chk("switch_pending", {31'h0, switch_pending}, 0);
  endtask
  task automatic t_direct();
    cfg(2'h3, 1'b0, 10'h0, 1'b0, 2'h3);
    meas();
    chk("direct high", hi, 3);
    chk("direct period", per, 7);
  endtask
  task automatic t_presc(logic [9:0] fld, logic oi, int h);
    int k;
    k = fld + 1;
    cfg(2'h2, 1'b1, fld, oi, 2'h2);
    meas();
    meas();
    chk("presc high", hi, k == 1 ? h : k / 2 * 2 * h);
    chk("presc period", per, 2 * h * k);
  endtask
  task automatic t_wakeup();
    cfg(2'h0, 1'b0, 10'h0, 1'b0, 2'h0);
    meas();
    chk("wakeup period", per, 10);
  endtask
  task automatic t_loop();
    cfg(2'h2, 1'b0, 10'h0, 1'b0, 2'h1);
    chk("loop enable", {31'h0, loop_enable}, 1);
    meas();
    chk("loop period", per, 6);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_direct();
    t_presc(10'h0, 1'b0, 3);
    t_presc(10'h0, 1'b1, 4);
    t_presc(10'h2, 1'b0, 3);
    t_wakeup();
    t_loop();
    t_presc(10'h3ff, 1'b0, 3);
    end_sim();
  end
endmodule
`default_nettype wire
